// [rtl/ppac_top.sv]
// ppac_top.sv: six 8-bit pulse channels with two prescalers, left or
// center alignment and pairing into 16-bit channels, on AXI4-Lite.
// assumes: one bus clock, synchronous reset, master on the same clock.
//
// Overview of operation
// - clock B is bus clock over 1..128, ch 2-3
// - clock A is bus clock over 1..128, others
// - per-channel bit picks center or left alignment
// - three join bits pair channels into 16 bits
// - lower-numbered channel is the high byte
// - joined channel counts on low-order channel clock
// - joined waveform leaves on low-order channel pin
// - low-order polarity bit sets joined output polarity
// - only low-order enable runs joined; high pin off
// - any counter byte write clears whole 16 bits
// - low-order alignment bit rules the joined channel
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`include "ppac_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ppac_top (
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	input  wire ppac_pkg::ppac_axil_req_s axil_req,
	output wire ppac_pkg::ppac_axil_rsp_s axil_rsp,
	output wire logic [5:0]               pwm_out
);
	import ppac_pkg::*;

	// ****************************************************************
	// declarations
	// ****************************************************************
	localparam int NPAIR = 3;

	logic [5:0]  enable_reg;
	logic [5:0]  enable_next;
	logic [5:0]  polarity_reg;
	logic [5:0]  polarity_next;
	logic [5:0]  center_align_enable_reg;
	logic [5:0]  center_align_enable_next;
	logic [2:0]  pulse_control_reg;
	logic [2:0]  pulse_control_next;
	logic [7:0]  prescale_clock_select_reg;
	logic [7:0]  prescale_clock_select_next;
	logic [47:0] period_reg;
	logic [47:0] period_next;
	logic [47:0] duty_reg;
	logic [47:0] duty_next;
	logic        aw_held_reg;
	logic        aw_held_next;
	logic [7:0]  awaddr_hold_reg;
	logic [7:0]  awaddr_hold_next;
	logic        w_held_reg;
	logic        w_held_next;
	logic [7:0]  wbyte_reg;
	logic [7:0]  wbyte_next;
	logic        wstb_reg;
	logic        wstb_next;
	ppac_axil_rsp_s rsp_reg;
	ppac_axil_rsp_s rsp_next;
	logic [6:0]  presc_reg;
	logic [6:0]  presc_next;
	logic        wr_go;
	logic [5:0]  cnt_clr;
	logic [2:0]  wr_idx;
	logic [31:0] rd_data;
	logic        rd_ok;
	logic [2:0]  rd_idx;
	logic [6:0]  mask_a;
	logic [6:0]  mask_b;
	logic        tick_a;
	logic        tick_b;
	logic [5:0]  tick_ch;
	wire logic [47:0] cnt_view;

	// one counting step, returns {direction, count}; down is 1
	function automatic logic [16:0] ppac_step(
		input logic [15:0] c,
		input logic        d,
		input logic [15:0] p,
		input logic        ca
	);
		if (p == 16'h0000)
			return 17'h00000;
		if (!ca)
			return (c >= p - 16'h0001) ? 17'h00000 : {1'b0, c + 16'h0001};
		if (!d)
			return (c >= p) ? {1'b1, c - 16'h0001} : {1'b0, c + 16'h0001};
		return (c == 16'h0000) ? {1'b0, c + 16'h0001}
		                       : {1'b1, c - 16'h0001};
	endfunction : ppac_step

	// ****************************************************************
	// prescaler
	// ****************************************************************

	// free-running divider, wraps every 128 bus clocks
	always_comb
	begin
		presc_next = presc_reg + 7'h01;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			presc_reg <= '0;
		else
			presc_reg <= presc_next;
	end

	// a code of k fires once every 2**k cycles; code 0 fires always
	assign mask_a = 7'((8'h01 << prescale_clock_select_reg[
		`PPAC_CLKA_LSB +: `PPAC_SEL_W]) - 8'h01);
	assign mask_b = 7'((8'h01 << prescale_clock_select_reg[
		`PPAC_CLKB_LSB +: `PPAC_SEL_W]) - 8'h01);
	assign tick_a = &(presc_reg | ~mask_a);
	assign tick_b = &(presc_reg | ~mask_b);
	// channels 2 and 3 run on clock B, the rest on clock A
	assign tick_ch = {tick_a, tick_a, tick_b, tick_b, tick_a, tick_a};

	// ****************************************************************
	// register bus: write path
	// ****************************************************************

	// address and data are caught in either order, then applied once
	always_comb
	begin
		enable_next                = enable_reg;
		polarity_next              = polarity_reg;
		center_align_enable_next   = center_align_enable_reg;
		pulse_control_next         = pulse_control_reg;
		prescale_clock_select_next = prescale_clock_select_reg;
		period_next                = period_reg;
		duty_next                  = duty_reg;
		aw_held_next               = aw_held_reg;
		awaddr_hold_next           = awaddr_hold_reg;
		w_held_next                = w_held_reg;
		wbyte_next                 = wbyte_reg;
		wstb_next                  = wstb_reg;
		rsp_next                   = rsp_reg;
		cnt_clr                    = '0;
		wr_idx                     = awaddr_hold_reg[4:2];
		wr_go = aw_held_reg & w_held_reg & ~rsp_reg.bvalid;
		if (axil_req.awvalid && rsp_reg.awready)
		begin
			aw_held_next     = 1'b1;
			awaddr_hold_next = axil_req.awaddr & `PPAC_WORD_MASK;
		end
		if (axil_req.wvalid && rsp_reg.wready)
		begin
			w_held_next = 1'b1;
			wbyte_next  = axil_req.wdata[7:0];
			wstb_next   = axil_req.wstrb[0];
		end
		if (rsp_reg.bvalid && axil_req.bready)
			rsp_next.bvalid = 1'b0;
		if (wr_go)
		begin
			aw_held_next    = 1'b0;
			w_held_next     = 1'b0;
			rsp_next.bvalid = 1'b1;
			rsp_next.bresp  = `PPAC_RESP_OKAY;
			case (awaddr_hold_reg & `PPAC_BANK_MASK)
				`PPAC_OFS_COUNT:
					if (wr_idx < 3'd6)
						cnt_clr[wr_idx] = 1'b1;
					else
						rsp_next.bresp = `PPAC_RESP_SLVERR;
				`PPAC_OFS_PERIOD:
					if (wr_idx < 3'd6 && wstb_reg)
						period_next[{wr_idx, 3'b000} +: 8] = wbyte_reg;
					else if (wr_idx >= 3'd6)
						rsp_next.bresp = `PPAC_RESP_SLVERR;
				`PPAC_OFS_DUTY:
					if (wr_idx < 3'd6 && wstb_reg)
						duty_next[{wr_idx, 3'b000} +: 8] = wbyte_reg;
					else if (wr_idx >= 3'd6)
						rsp_next.bresp = `PPAC_RESP_SLVERR;
				default:
					if (awaddr_hold_reg == `PPAC_OFS_ENABLE)
					begin
						if (wstb_reg)
							enable_next = wbyte_reg[5:0];
					end
					else if (awaddr_hold_reg == `PPAC_OFS_POLARITY)
					begin
						if (wstb_reg)
							polarity_next = wbyte_reg[5:0];
					end
					else if (awaddr_hold_reg == `PPAC_OFS_PRESCALE)
					begin
						if (wstb_reg)
							prescale_clock_select_next = wbyte_reg &
								`PPAC_PRESCALE_MASK;
					end
					else if (awaddr_hold_reg == `PPAC_OFS_CENTER)
					begin
						if (wstb_reg)
							center_align_enable_next = wbyte_reg[5:0];
					end
					else if (awaddr_hold_reg == `PPAC_OFS_CONTROL)
					begin
						if (wstb_reg)
							pulse_control_next = wbyte_reg[2:0];
					end
					else if (awaddr_hold_reg != `PPAC_OFS_STATUS)
						rsp_next.bresp = `PPAC_RESP_SLVERR;
			endcase
		end
		rsp_next.awready = ~aw_held_next;
		rsp_next.wready  = ~w_held_next;

		// read channel: one outstanding read, answered one cycle later
		if (axil_req.arvalid && rsp_reg.arready)
		begin
			rsp_next.rvalid = 1'b1;
			rsp_next.rdata  = rd_data;
			rsp_next.rresp  = rd_ok ? `PPAC_RESP_OKAY : `PPAC_RESP_SLVERR;
		end
		else if (rsp_reg.rvalid && axil_req.rready)
			rsp_next.rvalid = 1'b0;
		rsp_next.arready = ~rsp_next.rvalid;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			enable_reg                <= '0;
			polarity_reg              <= '0;
			center_align_enable_reg   <= '0;
			pulse_control_reg         <= '0;
			prescale_clock_select_reg <= `PPAC_RST_BYTE;
			period_reg                <= '0;
			duty_reg                  <= '0;
			aw_held_reg               <= 1'b0;
			awaddr_hold_reg           <= `PPAC_RST_BYTE;
			w_held_reg                <= 1'b0;
			wbyte_reg                 <= `PPAC_RST_BYTE;
			wstb_reg                  <= 1'b0;
			rsp_reg                   <= '0;
		end
		else
		begin
			enable_reg                <= enable_next;
			polarity_reg              <= polarity_next;
			center_align_enable_reg   <= center_align_enable_next;
			pulse_control_reg         <= pulse_control_next;
			prescale_clock_select_reg <= prescale_clock_select_next;
			period_reg                <= period_next;
			duty_reg                  <= duty_next;
			aw_held_reg               <= aw_held_next;
			awaddr_hold_reg           <= awaddr_hold_next;
			w_held_reg                <= w_held_next;
			wbyte_reg                 <= wbyte_next;
			wstb_reg                  <= wstb_next;
			rsp_reg                   <= rsp_next;
		end
	end

	// ****************************************************************
	// register bus: read decode
	// ****************************************************************

	// a low-order counter read of a joined pair returns all 16 bits
	always_comb
	begin
		rd_idx  = axil_req.araddr[4:2];
		rd_data = '0;
		rd_ok   = (rd_idx < 3'd6);
		case (axil_req.araddr & `PPAC_BANK_MASK)
			`PPAC_OFS_COUNT:
				if (rd_idx[0] && pulse_control_reg[rd_idx[2:1]] && rd_ok)
					rd_data[15:0] = {cnt_view[{rd_idx - 3'd1, 3'b000} +: 8],
					                 cnt_view[{rd_idx, 3'b000} +: 8]};
				else if (rd_ok)
					rd_data[7:0] = cnt_view[{rd_idx, 3'b000} +: 8];
			`PPAC_OFS_PERIOD:
				if (rd_ok)
					rd_data[7:0] = period_reg[{rd_idx, 3'b000} +: 8];
			`PPAC_OFS_DUTY:
				if (rd_ok)
					rd_data[7:0] = duty_reg[{rd_idx, 3'b000} +: 8];
			default:
			begin
				rd_ok = 1'b1;
				case (axil_req.araddr & `PPAC_WORD_MASK)
					`PPAC_OFS_ENABLE:   rd_data[5:0] = enable_reg;
					`PPAC_OFS_POLARITY: rd_data[5:0] = polarity_reg;
					`PPAC_OFS_PRESCALE: rd_data[7:0] = prescale_clock_select_reg;
					`PPAC_OFS_CENTER:   rd_data[5:0] = center_align_enable_reg;
					`PPAC_OFS_CONTROL:  rd_data[2:0] = pulse_control_reg;
					`PPAC_OFS_STATUS:   rd_data[5:0] = pwm_out;
					default:            rd_ok = 1'b0;
				endcase
			end
		endcase
	end

	// ****************************************************************
	// channel pairs
	// ****************************************************************
	for (genvar g = 0; g < NPAIR; g++)
	begin : g_pair
		localparam int HI = 2 * g;
		localparam int LO = 2 * g + 1;

		logic [7:0]  cnt_hi_reg;
		logic [7:0]  cnt_hi_next;
		logic [7:0]  cnt_lo_reg;
		logic [7:0]  cnt_lo_next;
		logic [1:0]  dir_reg;
		logic [1:0]  dir_next;
		logic [1:0]  out_reg;
		logic [1:0]  out_next;
		logic [16:0] st16;
		logic [16:0] sthi;
		logic [16:0] stlo;
		logic [15:0] per16;
		logic [15:0] duty16;

		// index 1 is the even channel, index 0 the odd channel
		always_comb
		begin
			cnt_hi_next = cnt_hi_reg;
			cnt_lo_next = cnt_lo_reg;
			dir_next    = dir_reg;
			out_next    = out_reg;
			per16  = {period_reg[8*HI +: 8], period_reg[8*LO +: 8]};
			duty16 = {duty_reg[8*HI +: 8], duty_reg[8*LO +: 8]};
			st16 = ppac_step({cnt_hi_reg, cnt_lo_reg}, dir_reg[0], per16,
			                 center_align_enable_reg[LO]);
			sthi = ppac_step({8'h00, cnt_hi_reg}, dir_reg[1],
			                 {8'h00, period_reg[8*HI +: 8]},
			                 center_align_enable_reg[HI]);
			stlo = ppac_step({8'h00, cnt_lo_reg}, dir_reg[0],
			                 {8'h00, period_reg[8*LO +: 8]},
			                 center_align_enable_reg[LO]);
			if (pulse_control_reg[g])
			begin
				out_next[1] = 1'b0;
				dir_next[1] = 1'b0;
				if (cnt_clr[HI] || cnt_clr[LO] || !enable_reg[LO])
				begin
					cnt_hi_next = '0;
					cnt_lo_next = '0;
					dir_next[0] = 1'b0;
				end
				else if (tick_ch[LO])
				begin
					dir_next[0] = st16[16];
					cnt_hi_next = st16[15:8];
					cnt_lo_next = st16[7:0];
				end
				out_next[0] = enable_reg[LO] &
				              ~(polarity_reg[LO] ^
				                ({cnt_hi_reg, cnt_lo_reg} < duty16));
			end
			else
			begin
				if (cnt_clr[HI] || !enable_reg[HI])
				begin
					cnt_hi_next = '0;
					dir_next[1] = 1'b0;
				end
				else if (tick_ch[HI])
				begin
					dir_next[1] = sthi[16];
					cnt_hi_next = sthi[7:0];
				end
				if (cnt_clr[LO] || !enable_reg[LO])
				begin
					cnt_lo_next = '0;
					dir_next[0] = 1'b0;
				end
				else if (tick_ch[LO])
				begin
					dir_next[0] = stlo[16];
					cnt_lo_next = stlo[7:0];
				end
				out_next[1] = enable_reg[HI] &
				              ~(polarity_reg[HI] ^
				                (cnt_hi_reg < duty_reg[8*HI +: 8]));
				out_next[0] = enable_reg[LO] &
				              ~(polarity_reg[LO] ^
				                (cnt_lo_reg < duty_reg[8*LO +: 8]));
			end
		end

		always_ff @(posedge clk)
		begin
			if (!reset_n)
			begin
				cnt_hi_reg <= '0;
				cnt_lo_reg <= '0;
				dir_reg    <= '0;
				out_reg    <= '0;
			end
			else
			begin
				cnt_hi_reg <= cnt_hi_next;
				cnt_lo_reg <= cnt_lo_next;
				dir_reg    <= dir_next;
				out_reg    <= out_next;
			end
		end

		// pins and counter views, straight from the pair's flops
		assign pwm_out[HI]           = out_reg[1];
		assign pwm_out[LO]           = out_reg[0];
		assign cnt_view[8*HI +: 8]   = cnt_hi_reg;
		assign cnt_view[8*LO +: 8]   = cnt_lo_reg;
	end

	assign axil_rsp = rsp_reg;

endmodule : ppac_top

`default_nettype wire

// [shared/ppac_params.svh]
// ppac_params.svh: register map, field positions, reset values and bus
// codes for the six-channel pulse generator.
// assumes: included by bare name wherever these constants are needed.
`ifndef PPAC_PARAMS_SVH
`define PPAC_PARAMS_SVH

// ********************************************************************
// bus geometry
// ********************************************************************
`define PPAC_ADDR_W       8
`define PPAC_DATA_W       32

// ********************************************************************
// register byte offsets
// ********************************************************************
`define PPAC_OFS_ENABLE   8'h00
`define PPAC_OFS_POLARITY 8'h04
`define PPAC_OFS_PRESCALE 8'h08
`define PPAC_OFS_CENTER   8'h0c
`define PPAC_OFS_CONTROL  8'h10
`define PPAC_OFS_STATUS   8'h14
`define PPAC_OFS_COUNT    8'h20
`define PPAC_OFS_PERIOD   8'h40
`define PPAC_OFS_DUTY     8'h60
`define PPAC_BANK_MASK    8'he0
`define PPAC_WORD_MASK    8'hfc

// ********************************************************************
// field positions and reset values
// ********************************************************************
`define PPAC_CLKA_LSB     0
`define PPAC_CLKB_LSB     4
`define PPAC_SEL_W        3
`define PPAC_PRESCALE_MASK 8'h77
`define PPAC_RST_BYTE     8'h00

// ********************************************************************
// bus response codes
// ********************************************************************
`define PPAC_RESP_OKAY    2'b00
`define PPAC_RESP_SLVERR  2'b10

`endif

// [shared/ppac_pkg.sv]
// ppac_pkg.sv: carrier types for the register bus of the pulse generator.
// assumes: ppac_params.svh is on the include path.
`include "ppac_params.svh"

`default_nettype none

package ppac_pkg;

	// ****************************************************************
	// AXI4-Lite request, master to slave
	// ****************************************************************
	typedef struct packed {
		logic [`PPAC_ADDR_W-1:0] awaddr;
		logic                    awvalid;
		logic [`PPAC_DATA_W-1:0] wdata;
		logic [3:0]              wstrb;
		logic                    wvalid;
		logic                    bready;
		logic [`PPAC_ADDR_W-1:0] araddr;
		logic                    arvalid;
		logic                    rready;
	} ppac_axil_req_s;

	// ****************************************************************
	// AXI4-Lite response, slave to master
	// ****************************************************************
	typedef struct packed {
		logic                    awready;
		logic                    wready;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    arready;
		logic                    rvalid;
		logic [`PPAC_DATA_W-1:0] rdata;
		logic [1:0]              rresp;
	} ppac_axil_rsp_s;

endpackage : ppac_pkg

`default_nettype wire

// [test/ppac_top_asserts.sv]
// ppac_top_asserts.sv: register bus handshake checks for ppac_top.
// assumes: bound to ppac_top, one clock, synchronous active-low reset.
`include "ppac_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ppac_top_asserts (
	input wire logic                     clk,
	input wire logic                     reset_n,
	input wire ppac_pkg::ppac_axil_req_s axil_req,
	input wire ppac_pkg::ppac_axil_rsp_s axil_rsp,
	input wire logic [5:0]               pwm_out
);
	import ppac_pkg::*;

	// ****
	// handshakes seen at each edge
	// ****
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic aw_bad;

	// channel transfers and an address with no register behind it
	assign aw_hs  = axil_req.awvalid && axil_rsp.awready;
	assign w_hs   = axil_req.wvalid && axil_rsp.wready;
	assign ar_hs  = axil_req.arvalid && axil_rsp.arready;
	assign aw_bad = axil_req.awaddr[7] || (axil_req.awaddr[7:3] == 5'h03);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// ****
	// write and read channel timing
	// ****
	write_answer_a: assert property (
		aw_hs && w_hs |-> ##[1:2] axil_rsp.bvalid)
		else $error("write answer late");
	bresp_hold_a: assert property (
		axil_rsp.bvalid && !axil_req.bready
		|=> axil_rsp.bvalid && $stable(axil_rsp.bresp))
		else $error("write answer dropped early");
	bvalid_drop_a: assert property (
		axil_rsp.bvalid && axil_req.bready |=> !axil_rsp.bvalid)
		else $error("write answer repeated");
	bad_write_a: assert property (
		aw_hs && w_hs && aw_bad
		|-> ##[1:2] axil_rsp.bvalid && axil_rsp.bresp == `PPAC_RESP_SLVERR)
		else $error("unmapped write not refused");
	read_answer_a: assert property (
		ar_hs |-> ##[1:2] axil_rsp.rvalid)
		else $error("read answer late");
	rdata_hold_a: assert property (
		axil_rsp.rvalid && !axil_req.rready
		|=> axil_rsp.rvalid && $stable(axil_rsp.rdata))
		else $error("read data changed while waiting");
	rvalid_drop_a: assert property (
		axil_rsp.rvalid && axil_req.rready |=> !axil_rsp.rvalid)
		else $error("read answer repeated");
	read_busy_a: assert property (
		axil_rsp.rvalid |-> !axil_rsp.arready)
		else $error("second read accepted");
	refused_zero_a: assert property (
		axil_rsp.rvalid && axil_rsp.rresp == `PPAC_RESP_SLVERR
		|-> axil_rsp.rdata == '0)
		else $error("refused read carries data");

	// main scenarios reached
	cover property (axil_rsp.bvalid && axil_rsp.bresp == `PPAC_RESP_SLVERR);
	cover property (axil_rsp.rvalid && !axil_req.rready);
	cover property ($rose(pwm_out[1]));
	cover property ($rose(pwm_out[3]));
endmodule : ppac_top_asserts

bind ppac_top ppac_top_asserts u_ppac_top_asserts (
	.clk      (clk),
	.reset_n  (reset_n),
	.axil_req (axil_req),
	.axil_rsp (axil_rsp),
	.pwm_out  (pwm_out)
);

`default_nettype wire

// [test/ppac_pin_load.sv]
// ppac_pin_load.sv: loads on the six pulse pins, timing each pulse.
// assumes: pins change only after rising edges of clk.
`timescale 1ns/1ps
`default_nettype none

module ppac_pin_load (
	input  wire logic       clk,
	input  wire logic [5:0] pins,
	output var  int         rises [6],
	output var  int         per   [6],
	output var  int         high  [6]
);
	int         cyc = 0;
	int         t_rise [6];
	logic [5:0] prev = '0;

	// count rising edges, period between rises and width of each pulse
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		prev <= pins;
		for (int i = 0; i < 6; i++)
		begin
			if (pins[i] && !prev[i])
			begin
				rises[i] <= rises[i] + 1;
				per[i] <= cyc - t_rise[i];
				t_rise[i] <= cyc;
			end
			if (!pins[i] && prev[i])
				high[i] <= cyc - t_rise[i];
		end
	end
endmodule : ppac_pin_load

`default_nettype wire

// [test/testbench.sv]
// testbench.sv: register, prescaler, alignment and pairing checks.
// assumes: ppac_top, ppac_pin_load and the bound checker are compiled.
`include "ppac_params.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import ppac_pkg::*;

	logic           clk = 1'b0;
	logic           reset_n;
	ppac_axil_req_s req;
	ppac_axil_rsp_s rsp;
	logic [5:0]     pwm_out;
	int             rises [6];
	int             per   [6];
	int             high  [6];
	int             errors = 0;
	int             check_count = 0;
	int             duty;
	int             r0;
	logic [31:0]    lfsr = 32'h2467;
	logic [31:0]    rd;
	logic [1:0]     rs;

	// 200 MHz bus clock
	always #2.5 clk = ~clk;

	ppac_top u_ppac_top (.clk(clk), .reset_n(reset_n), .axil_req(req),
		.axil_rsp(rsp), .pwm_out(pwm_out));
	ppac_pin_load u_ppac_pin_load (.clk(clk),
		.pins(pwm_out), .rises(rises), .per(per), .high(high));

	// ****
	// helpers
	// ****
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr_next

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check_val

	// wait three pulses, then compare period and width (width<0 skips)
	task automatic check_pulse(input int ch, input int p, input int h);
		int n;
		n = rises[ch] + 3;
		while (rises[ch] < n)
			@(posedge clk);
		check_count++;
		if (per[ch] != p || (h >= 0 && high[ch] != h))
		begin
			errors++;
			$display("wrong value at %0t: pin %0d period %0d width %0d",
				$time, ch, per[ch], high[ch]);
		end
	endtask : check_pulse

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		@(posedge clk);
		aw = 1'b1;
		w = 1'b1;
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		while (aw || w)
		begin
			@(posedge clk);
			if (aw && rsp.awready)
				req.awvalid <= 1'b0;
			if (aw && rsp.awready)
				aw = 1'b0;
			if (w && rsp.wready)
				req.wvalid <= 1'b0;
			if (w && rsp.wready)
				w = 1'b0;
		end
		while (!rsp.bvalid)
			@(posedge clk);
		rs = rsp.bresp;
		req.bready <= 1'b0;
	endtask : axi_write

	// rready comes late on purpose so the slave must hold its answer
	task automatic axi_read(input logic [7:0] a);
		@(posedge clk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b0;
		do
			@(posedge clk);
		while (!rsp.arready);
		req.arvalid <= 1'b0;
		while (!rsp.rvalid)
			@(posedge clk);
		req.rready <= 1'b1;
		@(posedge clk);
		rd = rsp.rdata;
		rs = rsp.rresp;
		req.rready <= 1'b0;
	endtask : axi_read

	task automatic test_done();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	// ****
	// main sequence
	// ****
	initial
	begin
		req <= '0;
		reset_n <= 1'b0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		for (int a = 0; a < 8'h18; a += 4)
		begin
			axi_read(8'(a));
			check_val(rd, 32'h0);
		end
		axi_read(8'h18);
		check_val({rs, rd[29:0]}, {`PPAC_RESP_SLVERR, 30'h0});
		axi_write(8'h1c, 32'h1);
		check_val(32'(rs), 32'(`PPAC_RESP_SLVERR));
		axi_write(`PPAC_OFS_PRESCALE, 32'hff);
		axi_read(`PPAC_OFS_PRESCALE);
		check_val(rd, 32'h77);
		// channel 0 on clock A, channel 2 on clock B, every code
		axi_write(`PPAC_OFS_POLARITY, 32'h3f);
		axi_write(`PPAC_OFS_PERIOD, 32'h6);
		axi_write(`PPAC_OFS_PERIOD + 8'h08, 32'h6);
		axi_write(`PPAC_OFS_ENABLE, 32'h05);
		for (int k = 0; k < 8; k++)
		begin
			lfsr = lfsr_next(lfsr);
			duty = 1 + int'(lfsr[3:0]) % 5;
			axi_write(`PPAC_OFS_DUTY, 32'(duty));
			axi_write(`PPAC_OFS_DUTY + 8'h08, 32'(duty));
			axi_write(`PPAC_OFS_CENTER, 32'(k % 2));
			axi_write(`PPAC_OFS_PRESCALE, 32'(((7 - k) << 4) | k));
			// center pulses stay high 2*duty-1 ticks around zero
			check_pulse(0, (1 + k % 2) * (6 << k),
				(k % 2 ? 2 * duty - 1 : duty) << k);
			check_pulse(2, 6 << (7 - k), duty << (7 - k));
		end
		// join all pairs while off; only low-order settings may count
		axi_write(`PPAC_OFS_ENABLE, 32'h0);
		axi_write(`PPAC_OFS_CONTROL, 32'h7);
		axi_write(`PPAC_OFS_PRESCALE, 32'h00);
		axi_write(`PPAC_OFS_CENTER, 32'h15);
		axi_write(`PPAC_OFS_POLARITY, 32'h2a);
		for (int p = 0; p < 24; p += 8)
		begin
			axi_write(`PPAC_OFS_PERIOD + 8'(p), 32'h1);
			axi_write(`PPAC_OFS_PERIOD + 8'(p + 4), 32'h4);
			axi_write(`PPAC_OFS_DUTY + 8'(p), 32'h0);
			axi_write(`PPAC_OFS_DUTY + 8'(p + 4), 32'h64);
		end
		axi_write(`PPAC_OFS_ENABLE, 32'h15);
		axi_read(`PPAC_OFS_COUNT + 8'h04);
		check_val(rd, 32'h0);
		r0 = rises[0] + rises[2] + rises[4];
		axi_write(`PPAC_OFS_ENABLE, 32'h3f);
		for (int c = 1; c < 6; c += 2)
			check_pulse(c, 260, 100);
		check_val(32'(rises[0] + rises[2] + rises[4] - r0), 32'h0);
		for (int b = 0; b < 2; b++)
		begin
			axi_write(`PPAC_OFS_COUNT + 8'(4 * b), 32'h0);
			axi_read(`PPAC_OFS_COUNT + 8'h04);
			check_val(32'(rd < 32'h10), 32'h1);
		end
		test_done();
	end

	// cut a hang short
	initial
	begin
		repeat (40000) @(posedge clk);
		errors++;
		test_done();
	end
endmodule : testbench

`default_nettype wire
